// ===== common/kbd_pin_consts.vh
`ifndef KBD_PIN_CONSTS_VH
`define KBD_PIN_CONSTS_VH
`define SYNC_RESET_VAL 2'h0
`define BIT_LOW 1'h0
`define BIT_HIGH 1'h1
`define OSC_SYNC_RESET 3'h0
`endif

// ===== core/sync2.v
`timescale 1ns/1ps
`include "kbd_pin_consts.vh"
module sync2 (
    // Clock, reset and enable
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    // Data
    input wire d_i,
    output wire q_o
);
    reg [1:0] sync_reg;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_reg <= `SYNC_RESET_VAL;
        end else if (ce_i) begin
            sync_reg <= {sync_reg[0], d_i};
        end
    end
    assign q_o = sync_reg[1];
endmodule // sync2

// ===== core/kbd_mouse_rtc_pin_routing.v
`timescale 1ns/1ps
`include "kbd_pin_consts.vh"
module kbd_mouse_rtc_pin_routing (
    // Clock, reset, enable
    input wire clk_i,
    input wire resetn_i,
    input wire ce_i,
    // Control
    input wire kbd_ctrl_enable_bit_i,
    // Keyboard controller side
    input wire kbc_kclk_out_i,
    input wire kbc_kbd_data_pin_out_i,
    input wire kbc_mclk_out_i,
    input wire kbc_mdat_out_i,
    input wire ext_turbo_req_i,
    output reg kbc_kclk_in_o,
    output reg kbc_test_port_input_o,
    output reg kbc_port_pair_o,
    output reg kbc_mclk_in_o,
    output reg kbc_mdat_in_o,
    output reg turbo_req_o,
    output reg irq1_o,
    // Keyboard and pointer pins
    input wire kbd_clock_or_irq_pin_i,
    output reg kbd_clock_or_irq_pin_o,
    output reg kbd_clock_or_irq_pin_oe_o,
    input wire kbd_data_pin_i,
    output reg kbd_data_pin_o,
    output reg kbd_data_pin_oe_o,
    input wire pointer_clock_pin_i,
    output reg pointer_clock_pin_o,
    output reg pointer_clock_pin_oe_o,
    input wire pointer_data_or_speed_request_pin_i,
    output reg pointer_data_or_speed_request_pin_o,
    output reg pointer_data_or_speed_request_pin_oe_o,
    // Clock-calendar
    input wire rtc_irq_drive_i,
    input wire clock_calendar_irq_pin_i,
    output reg clock_calendar_irq_pin_o,
    output reg clock_calendar_irq_pin_oe_o,
    output reg irq8_o,
    input wire clock_calendar_osc_in_i,
    output reg rtc_tick_o
);
    // ==========================================
    // Reset release
    reg [1:0] rst_sync_reg;
    wire rst_n;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_reg <= `SYNC_RESET_VAL;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], `BIT_HIGH};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ==========================================
    // Pin synchronisers
    wire kclk_s;
    wire kbd_data_pin_s;
    wire mclk_s;
    wire mdat_s;
    wire rirq_s;
    wire osc_s;
    sync2 u_kclk (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce_i), .d_i(kbd_clock_or_irq_pin_i), .q_o(kclk_s));
    sync2 u_kbd_data_pin (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce_i), .d_i(kbd_data_pin_i), .q_o(kbd_data_pin_s));
    sync2 u_mclk (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce_i), .d_i(pointer_clock_pin_i), .q_o(mclk_s));
    sync2 u_mdat (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce_i),
        .d_i(pointer_data_or_speed_request_pin_i), .q_o(mdat_s));
    sync2 u_rirq (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce_i), .d_i(clock_calendar_irq_pin_i), .q_o(rirq_s));
    sync2 u_osc (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce_i), .d_i(clock_calendar_osc_in_i), .q_o(osc_s));

    // ==========================================
    // Routing
    reg osc_prev_reg;
    wire en;
    assign en = kbd_ctrl_enable_bit_i;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            kbc_kclk_in_o <= `BIT_HIGH;
            kbc_test_port_input_o <= `BIT_HIGH;
            kbc_port_pair_o <= `BIT_HIGH;
            kbc_mclk_in_o <= `BIT_HIGH;
            kbc_mdat_in_o <= `BIT_HIGH;
            turbo_req_o <= `BIT_LOW;
            irq1_o <= `BIT_LOW;
            kbd_clock_or_irq_pin_o <= `BIT_LOW;
            kbd_clock_or_irq_pin_oe_o <= `BIT_LOW;
            kbd_data_pin_o <= `BIT_LOW;
            kbd_data_pin_oe_o <= `BIT_LOW;
            pointer_clock_pin_o <= `BIT_LOW;
            pointer_clock_pin_oe_o <= `BIT_LOW;
            pointer_data_or_speed_request_pin_o <= `BIT_LOW;
            pointer_data_or_speed_request_pin_oe_o <= `BIT_LOW;
            clock_calendar_irq_pin_o <= `BIT_LOW;
            clock_calendar_irq_pin_oe_o <= `BIT_LOW;
            irq8_o <= `BIT_LOW;
            osc_prev_reg <= `BIT_LOW;
            rtc_tick_o <= `BIT_LOW;
        end else if (ce_i) begin
            // Keyboard clock or external IRQ1
            kbc_kclk_in_o <= en ? kclk_s : `BIT_HIGH;
            irq1_o <= en ? `BIT_LOW : kclk_s;
            kbd_clock_or_irq_pin_o <= `BIT_LOW;
            kbd_clock_or_irq_pin_oe_o <= en & ~kbc_kclk_out_i;
            // Keyboard data
            kbc_test_port_input_o <= en ? kbd_data_pin_s : `BIT_HIGH;
            kbc_port_pair_o <= en ? kbd_data_pin_s : `BIT_HIGH;
            kbd_data_pin_o <= `BIT_LOW;
            kbd_data_pin_oe_o <= en & ~kbc_kbd_data_pin_out_i;
            // Pointer clock
            kbc_mclk_in_o <= en ? mclk_s : `BIT_HIGH;
            pointer_clock_pin_o <= `BIT_LOW;
            pointer_clock_pin_oe_o <= en & ~kbc_mclk_out_i;
            // Pointer data or speed request
            kbc_mdat_in_o <= en ? mdat_s : `BIT_HIGH;
            pointer_data_or_speed_request_pin_o <= `BIT_LOW;
            pointer_data_or_speed_request_pin_oe_o <= en & ~kbc_mdat_out_i;
            turbo_req_o <= ext_turbo_req_i | (~en & mdat_s);
            // Clock-calendar interrupt, open drain
            clock_calendar_irq_pin_o <= `BIT_LOW;
            clock_calendar_irq_pin_oe_o <= rtc_irq_drive_i;
            irq8_o <= ~rirq_s;
            // Timebase tick on rising oscillator edge
            osc_prev_reg <= osc_s;
            rtc_tick_o <= osc_s & ~osc_prev_reg;
        end
    end
endmodule // kbd_mouse_rtc_pin_routing

// ===== tb/kmr_chk_assertions.sv
`timescale 1ns/1ps
module kmr_chk (
    input wire clk_i, resetn_i, kbd_ctrl_enable_bit_i, kbc_kbd_data_pin_out_i, ext_turbo_req_i, rtc_irq_drive_i,
    input wire pointer_data_or_speed_request_pin_i, clock_calendar_irq_pin_i, clock_calendar_osc_in_i,
    input wire kbd_data_pin_oe_o, pointer_clock_pin_oe_o, pointer_data_or_speed_request_pin_oe_o,
    input wire kbc_mdat_in_o, turbo_req_o, irq1_o, irq8_o, clock_calendar_irq_pin_oe_o, rtc_tick_o
);
    wire en = kbd_ctrl_enable_bit_i;
    wire md = pointer_data_or_speed_request_pin_i;
    reg [3:0] up_reg;
    always @(posedge clk_i or negedge resetn_i)
        if (!resetn_i) up_reg <= 4'h0;
        else if (up_reg != 4'hf) up_reg <= up_reg + 4'h1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (up_reg != 4'hf);
    sequence s_on; en[*3]; endsequence
    sequence s_off; (!en)[*3]; endsequence
    property p_kbd_data_pin; $past(en && !kbc_kbd_data_pin_out_i) |-> kbd_data_pin_oe_o; endproperty
    a_kbd_data_pin: assert property (p_kbd_data_pin) else $error("kbd_data_pin not driven");
    property p_hiz; $past(!en) |-> !(kbd_data_pin_oe_o | pointer_clock_pin_oe_o | pointer_data_or_speed_request_pin_oe_o); endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven while off");
    property p_mdat; s_on |=> kbc_mdat_in_o == $past(md, 3); endproperty
    a_mdat: assert property (p_mdat) else $error("pointer data lost");
    property p_detach; $past(!en) |-> kbc_mdat_in_o; endproperty
    a_detach: assert property (p_detach) else $error("pointer data leaks");
    property p_turbo; s_off |=> turbo_req_o == ($past(ext_turbo_req_i) | $past(md, 3)); endproperty
    a_turbo: assert property (p_turbo) else $error("speed request wrong");
    property p_rtc; clock_calendar_irq_pin_oe_o == $past(rtc_irq_drive_i); endproperty
    a_rtc: assert property (p_rtc) else $error("irq line drive wrong");
    property p_irq8; irq8_o != $past(clock_calendar_irq_pin_i, 3); endproperty
    a_irq8: assert property (p_irq8) else $error("irq8 not inverted");
    property p_irq1; $past(en) |-> !irq1_o; endproperty
    a_irq1: assert property (p_irq1) else $error("irq1 while on");
    property p_tick; $rose(clock_calendar_osc_in_i) |-> ##[1:4] rtc_tick_o ##1 !rtc_tick_o; endproperty
    a_tick: assert property (p_tick) else $error("tick missing");
endmodule // kmr_chk
bind kbd_mouse_rtc_pin_routing kmr_chk chk (.*);

// ===== tb/kmr_far.sv
`timescale 1ns/1ps
module kmr_far (
    // Enables and far pulls
    input wire [4:0] oe_i,
    input wire [4:0] pull_i,
    // Wire levels
    output wire [4:0] pin_o
);
    assign pin_o = ~(oe_i | pull_i);
endmodule // kmr_far

// ===== tb/kbd_mouse_rtc_pin_routing_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module kbd_mouse_rtc_pin_routing_bench;
    reg clk_i = 0, resetn_i = 0, en = 0, ext = 0, drv = 0, osc = 0, run = 0, smp = 0;
    reg [3:0] ko = 4'hf, koe, lv;
    reg [4:0] pull = 5'h0;
    reg [31:0] seed = 32'h30ff;
    reg [12:0] q[$];
    wire [4:0] oe, pin, kin;
    wire t, i1, i8, tick;
    int n_errors = 0, compares = 0, nr = 0, nt = 0, i;
    always #5 clk_i = ~clk_i;
    always #80 if (run) osc = ~osc;
    always @(posedge osc) nr++;
    always @(posedge clk_i) if (tick) nt++;
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin y = x ^ (x << 13); y = y ^ (y >> 17); xs = y ^ (y << 5); end
    endfunction
    kmr_far far (.oe_i(oe), .pull_i(pull), .pin_o(pin));
    kbd_mouse_rtc_pin_routing uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .kbd_ctrl_enable_bit_i(en),
        .kbc_kclk_out_i(ko[0]), .kbc_kbd_data_pin_out_i(ko[1]), .kbc_mclk_out_i(ko[2]), .kbc_mdat_out_i(ko[3]),
        .ext_turbo_req_i(ext), .kbc_kclk_in_o(kin[4]), .kbc_test_port_input_o(kin[3]), .kbc_port_pair_o(kin[2]),
        .kbc_mclk_in_o(kin[1]), .kbc_mdat_in_o(kin[0]), .turbo_req_o(t), .irq1_o(i1),
        .kbd_clock_or_irq_pin_i(pin[0]), .kbd_clock_or_irq_pin_o(), .kbd_clock_or_irq_pin_oe_o(oe[0]),
        .kbd_data_pin_i(pin[1]), .kbd_data_pin_o(), .kbd_data_pin_oe_o(oe[1]), .pointer_clock_pin_i(pin[2]),
        .pointer_clock_pin_o(), .pointer_clock_pin_oe_o(oe[2]), .pointer_data_or_speed_request_pin_i(pin[3]),
        .pointer_data_or_speed_request_pin_o(), .pointer_data_or_speed_request_pin_oe_o(oe[3]),
        .rtc_irq_drive_i(drv), .clock_calendar_irq_pin_i(pin[4]), .clock_calendar_irq_pin_o(),
        .clock_calendar_irq_pin_oe_o(oe[4]), .irq8_o(i8), .clock_calendar_osc_in_i(osc), .rtc_tick_o(tick));
    always @(posedge clk_i) if (smp) `CHK({oe, kin, t, i1, i8}, q.pop_front())
    task summarize; begin
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end endtask
    initial begin
        repeat (16) @(negedge clk_i);
        resetn_i = 1;
        run = 1;
        repeat (8) @(negedge clk_i);
        for (i = 0; i < 120; i++) begin
            seed = xs(seed);
            {en, ext, drv, ko, pull} = seed[11:0];
            koe = en ? ~ko : 4'h0;
            lv = ~(koe | pull[3:0]);
            repeat (6) @(negedge clk_i);
            q.push_back({drv, koe, en ? {lv[0], lv[1], lv[1], lv[2], lv[3]} : 5'h1f, ext | (!en & lv[3]), !en & lv[0], drv | pull[4]});
            smp = 1;
            @(negedge clk_i);
            smp = 0;
        end
        run = 0;
        repeat (20) @(negedge clk_i);
        `CHK(nt, nr)
        $display("test random_routing done");
        summarize;
    end
endmodule // kbd_mouse_rtc_pin_routing_bench
